// [sim/adc_pair_interleave_serial_out_tb.sv]
`timescale 1ns/1ns
module adc_pair_interleave_serial_out_tb;
	logic REF_CLK = 0, RST_N = 0, CLKIN = 0, SYNC = 0, SEN_N = 1, SCLK = 0, SDATA = 0;
	logic hold_req = 0, run = 0;
	logic [11:0] ADC_IN_A = 0, ADC_IN_B = 0, a_tmp, rx_a, rx_b;
	logic DOUT_A, DOUT_B, DCLK, FCLK, SAMPLE_PHASE, SAMPLE_READY, CURVE_RUN, LINK_HOLD;
	logic rx_valid;
	logic [8:0] GAIN_CODE;
	logic [31:0] seed = 32'h291e_4228;
	logic [23:0] corner[4] = '{24'h800_7ff, 24'h000_fff, 24'h7ff_800, 24'hfff_001};
	logic [23:0] exp_q[$];
	int error_cnt = 0, tests_run = 0, rises = 0, rx_n = 0, fault_cnt;

	adc_pair_serial dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLKIN(CLKIN),
		.ADC_IN_A(ADC_IN_A), .ADC_IN_B(ADC_IN_B), .SYNC(SYNC), .SEN_N(SEN_N),
		.SCLK(SCLK), .SDATA(SDATA), .LINK_HOLD(LINK_HOLD), .DOUT_A(DOUT_A),
		.DOUT_B(DOUT_B), .DCLK(DCLK), .FCLK(FCLK), .SAMPLE_PHASE(SAMPLE_PHASE),
		.SAMPLE_READY(SAMPLE_READY), .GAIN_CODE(GAIN_CODE), .CURVE_RUN(CURVE_RUN));
	link_receiver rx (.clk(REF_CLK), .rst_n(RST_N), .dout_a(DOUT_A), .dout_b(DOUT_B),
		.dclk(DCLK), .fclk(FCLK), .hold_req(hold_req), .link_hold(LINK_HOLD),
		.rx_valid(rx_valid), .rx_a(rx_a), .rx_b(rx_b), .fault_cnt(fault_cnt));

	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [11:0] obin(logic [11:0] v);
		return {~v[11], v[10:0]};
	endfunction
	task check(logic [23:0] seen, logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cyc(int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task end_of_test;
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// sel 1 waits on SAMPLE_READY, 0 on CURVE_RUN
	task automatic wait_sig(bit sel, logic v);
		for (int i = 0; i < 400; i++) begin
			if ((sel ? SAMPLE_READY : CURVE_RUN) === v)
				return;
			cyc(1);
		end
		error_cnt++;
		end_of_test;
	endtask
	task automatic spi_write(logic [7:0] a, logic [15:0] d);
		logic [23:0] w;
		w = {a, d};
		SEN_N <= 0;
		cyc(4);
		for (int i = 23; i >= 0; i--) begin
			SDATA <= w[i];
			SCLK <= 0;
			cyc(4);
			SCLK <= 1;
			cyc(4);
		end
		SCLK <= 0;
		cyc(4);
		SEN_N <= 1;
		SDATA <= 0;
		cyc(4);
	endtask

	always #20 REF_CLK = ~REF_CLK;
	// link clock: own phase, parks low when stopped
	initial begin
		#7;
		forever begin
			#160;
			if (run || CLKIN)
				CLKIN = ~CLKIN;
		end
	end
	always @(posedge CLKIN) begin
		rises++;
		if (rises[0])
			a_tmp = ADC_IN_A;
		else
			exp_q.push_back({obin(a_tmp), obin(ADC_IN_B)});
	end
	always @(negedge CLKIN) begin
		check(SAMPLE_PHASE, rises[0]);
		seed = xs(seed);
		if (rises < 5)
			{ADC_IN_A, ADC_IN_B} <= corner[rises-1];
		else
			{ADC_IN_A, ADC_IN_B} <= {seed[11:0], seed[27:16]};
	end
	always @(posedge REF_CLK) begin
		if (rx_valid) begin
			check({rx_a, rx_b}, exp_q.size() ? exp_q.pop_front() : 24'hx);
			check(rises - 2*rx_n >= 13 && (rx_n > 5 || rises - 2*rx_n <= 15), 1);
			rx_n++;
		end
	end

	initial begin
		cyc(12);
		RST_N <= 1;
		cyc(3);
		check({GAIN_CODE, CURVE_RUN, SAMPLE_PHASE, SAMPLE_READY, FCLK}, 13'h0002);
		run = 1;
		cyc(240);
		hold_req <= 1;
		wait_sig(1, 0);
		run = 0;
		cyc(8);
		check(SAMPLE_READY, 0);
		hold_req <= 0;
		wait_sig(1, 1);
		run = 1;
		cyc(160);
		run = 0;
		// drain the backlog left by the hold before counting words
		cyc(200);
		check(rx_n, (rises - 13) / 2 + 1);
		spi_write(8'h01, 16'h00a5);
		check(GAIN_CODE, 9'h0a5);
		spi_write(8'h01, 16'h01ff);
		check(GAIN_CODE, 9'h120);
		spi_write(8'h00, 16'h0004);
		spi_write(8'h01, 16'h0120);
		spi_write(8'h02, 16'h0003);
		spi_write(8'h00, 16'h0000);
		SYNC <= 1;
		cyc(4);
		SYNC <= 0;
		wait_sig(0, 1);
		cyc(2);
		check(GAIN_CODE, 9'h120);
		// one link clock rise steps the curve once
		run = 1;
		cyc(6);
		run = 0;
		cyc(8);
		check(GAIN_CODE, 9'h003);
		spi_write(8'h03, 16'h0001);
		check({GAIN_CODE, CURVE_RUN}, {9'h120, 1'b1});
		spi_write(8'h00, 16'h0001);
		check({GAIN_CODE, CURVE_RUN}, 10'h0);
		spi_write(8'h01, 16'h0055);
		check(GAIN_CODE, 9'h055);
		SYNC <= 1;
		cyc(4);
		SYNC <= 0;
		cyc(6);
		check({GAIN_CODE, CURVE_RUN}, {9'h000, 1'b1});
		check(fault_cnt, 0);
		end_of_test;
	end
endmodule

// [sim/link_receiver.sv]
`timescale 1ns/1ns
module link_receiver (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dout_a,
	input wire logic dout_b,
	input wire logic dclk,
	input wire logic fclk,
	input wire logic hold_req,
	output logic link_hold,
	output logic rx_valid,
	output logic [11:0] rx_a,
	output logic [11:0] rx_b,
	output int fault_cnt
);
	logic dclk_q, fclk_q, armed;
	logic [10:0] sh_a, sh_b;
	int idx;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{link_hold, rx_valid, dclk_q, fclk_q, armed} <= '0;
			idx <= 0;
			fault_cnt <= 0;
		end else begin
			link_hold <= hold_req;
			dclk_q <= dclk;
			fclk_q <= fclk;
			armed <= armed | dclk;
			rx_valid <= 1'b0;
			sh_a <= {sh_a[9:0], dout_a};
			sh_b <= {sh_b[9:0], dout_b};
			if (armed && dclk == dclk_q)
				fault_cnt <= fault_cnt + 1;
			if (fclk && !fclk_q) begin
				if (idx != 0)
					fault_cnt <= fault_cnt + 1;
				idx <= 1;
			end else if (idx != 0) begin
				if (fclk != (idx < 6))
					fault_cnt <= fault_cnt + 1;
				idx <= (idx == 11) ? 0 : idx + 1;
				if (idx == 11) begin
					rx_valid <= 1'b1;
					rx_a <= {sh_a, dout_a};
					rx_b <= {sh_b, dout_b};
				end
			end
		end
	end
endmodule

// [src/adc_pair_serial.sv]
// Functional notes
// [R1] one converter serves two channels, taken on alternate input clock rising edges
// [R2] each channel therefore runs at half the input clock rate
// [R3] each 12-bit result leaves the pipeline 11 input clock edges after sampling
// [R4] each channel has its own serial lane, straight offset binary coding
// [R5] a bit clock and a frame clock run beside the data lanes
// [R6] frame clock rises with the first bit of every word
// [R7] one bit per bit clock edge, double data rate
// [R8] a sync pin pulse starts the gain curve for all channels together
// [R9] a software command over the programming port also starts the curve
// [R10] gain code steps of 0.125 dB from -5 dB to 31 dB
// [R11] one curve memory, loaded over the programming port, shared by all channels
// [R12] the controller pulses reset before relying on the device
// [R13] reset clears every control register to zero
// [R14] each 24-clock group under low enable writes 8-bit address plus 16-bit data
// [R15] software reset bit at address zero resets the device and clears itself; the code resets only the control registers and the gain curve
// [R16] words are sent most significant bit first
`timescale 1ns/1ns
`include "afe_stream_regs.svh"
module adc_pair_serial #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLKIN,
	input wire logic [11:0] ADC_IN_A,
	input wire logic [11:0] ADC_IN_B,
	input wire logic SYNC,
	input wire logic SEN_N,
	input wire logic SCLK,
	input wire logic SDATA,
	input wire logic LINK_HOLD,
	output logic DOUT_A,
	output logic DOUT_B,
	output logic DCLK,
	output logic FCLK,
	output logic SAMPLE_PHASE,
	output logic SAMPLE_READY,
	output logic [8:0] GAIN_CODE,
	output logic CURVE_RUN
);
	localparam int PIN_W = 30;
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [5:0] ctl_d_r;
	logic clkin_s, sync_s, sen_n_s, sclk_s, sdata_s, hold_s;
	logic [11:0] adc_a_s;
	logic [11:0] adc_b_s;
	logic clk_edge;
	logic sync_pin_evt;

	// two-stage synchronisers for every pin other than REF_CLK and RST_N; edges are found after stage two
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			ctl_d_r <= '0;
		end else begin
			pin_s1_r <= {CLKIN, SYNC, SEN_N, SCLK, SDATA, LINK_HOLD, ADC_IN_A, ADC_IN_B};
			pin_s2_r <= pin_s1_r;
			ctl_d_r <= pin_s2_r[29:24];
		end
	end
	assign {clkin_s, sync_s, sen_n_s, sclk_s, sdata_s, hold_s} = pin_s2_r[29:24];
	assign adc_a_s = pin_s2_r[23:12];
	assign adc_b_s = pin_s2_r[11:0];
	assign clk_edge = clkin_s && !ctl_d_r[5];
	assign sync_pin_evt = sync_s && !ctl_d_r[4];

	// ---------------- converter pair and pipeline ----------------
	logic phase_r;
	logic [11:0] samp_sel;
	logic [12:0] pipe_r [0:`PIPE_LAT-1];
	logic [11:0] word_a_r;
	logic [4:0] fill_r;
	logic emerge;
	logic [12:0] out_word;
	logic pair_valid;
	logic [`PAIR_W-1:0] pair_data;

	function automatic logic [11:0] to_offset_bin(input logic [11:0] twos);
		to_offset_bin = {~twos[11], twos[10:0]};
	endfunction

	assign samp_sel = phase_r ? adc_b_s : adc_a_s;
	assign out_word = pipe_r[`PIPE_LAT-1];
	assign emerge = clk_edge && (fill_r >= 5'(`PIPE_LAT));

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			phase_r <= 1'b0;
		else if (clk_edge)
			phase_r <= ~phase_r; // [R1] [R2]
	end

	always_ff @(posedge REF_CLK) begin
		if (clk_edge)
			pipe_r[0] <= {phase_r, to_offset_bin(samp_sel)}; // [R4]
	end

	genvar gi;
	generate
		for (gi = 1; gi < `PIPE_LAT; gi++) begin : g_pipe
			always_ff @(posedge REF_CLK) begin
				if (clk_edge)
					pipe_r[gi] <= pipe_r[gi-1]; // [R3]
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			fill_r <= '0;
		else if (clk_edge && fill_r < 5'(`PIPE_LAT))
			fill_r <= fill_r + 5'h01;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			word_a_r <= '0;
		else if (emerge && !out_word[12])
			word_a_r <= out_word[11:0];
	end

	assign pair_valid = emerge && out_word[12];
	assign pair_data = {word_a_r, out_word[11:0]};
	assign SAMPLE_PHASE = phase_r;

	// ---------------- buffer and serializer ----------------
	logic fifo_valid;
	logic fifo_pop;
	logic [`PAIR_W-1:0] fifo_data;
	afe_stream_pkg::ser_state_t ser_r;
	logic [11:0] sh_a_r;
	logic [11:0] sh_b_r;
	logic [3:0] bit_r;
	logic take;

	word_fifo #(.WIDTH(`PAIR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.in_valid(pair_valid),
		.in_ready(SAMPLE_READY),
		.in_data(pair_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	assign take = fifo_valid && !hold_s;
	assign fifo_pop = take && (ser_r == afe_stream_pkg::SER_IDLE || bit_r == 4'hb);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ser_r <= afe_stream_pkg::SER_IDLE;
			bit_r <= '0;
			sh_a_r <= '0;
			sh_b_r <= '0;
		end else begin
			unique case (ser_r)
				afe_stream_pkg::SER_IDLE: begin
					if (fifo_pop) begin
						sh_a_r <= fifo_data[23:12];
						sh_b_r <= fifo_data[11:0];
						bit_r <= '0;
						ser_r <= afe_stream_pkg::SER_SHIFT;
					end
				end
				afe_stream_pkg::SER_SHIFT: begin
					if (fifo_pop) begin
						sh_a_r <= fifo_data[23:12];
						sh_b_r <= fifo_data[11:0];
						bit_r <= '0;
					end else begin
						sh_a_r <= {sh_a_r[10:0], 1'b0};
						sh_b_r <= {sh_b_r[10:0], 1'b0};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'hb)
							ser_r <= afe_stream_pkg::SER_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			DOUT_A <= 1'b0;
			DOUT_B <= 1'b0;
			FCLK <= 1'b0;
		end else if (ser_r == afe_stream_pkg::SER_SHIFT) begin
			DOUT_A <= sh_a_r[11]; // [R16]
			DOUT_B <= sh_b_r[11]; // [R4]
			FCLK <= (bit_r < 4'(`FRAME_HALF)); // [R6]
		end else begin
			DOUT_A <= 1'b0;
			DOUT_B <= 1'b0;
			FCLK <= 1'b0;
		end
	end

	// bit clock toggles every cycle: each edge carries one new bit while the serializer is in SER_SHIFT
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			DCLK <= 1'b0;
		else
			DCLK <= ~DCLK; // [R5] [R7]
	end

	// ---------------- serial programming port ----------------
	logic [22:0] spi_sh_r;
	logic [4:0] spi_cnt_r;
	logic sclk_rise;
	logic spi_wr;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;

	assign sclk_rise = sclk_s && !ctl_d_r[2] && !sen_n_s;
	assign spi_wr = sclk_rise && spi_cnt_r == `SPI_LAST; // [R14]
	assign wr_addr = spi_sh_r[22:15];
	assign wr_data = {spi_sh_r[14:0], sdata_s};

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			spi_sh_r <= '0;
			spi_cnt_r <= '0;
		end else if (sen_n_s) begin
			spi_cnt_r <= '0;
		end else if (sclk_rise) begin
			spi_sh_r <= {spi_sh_r[21:0], sdata_s};
			spi_cnt_r <= spi_wr ? 5'h00 : spi_cnt_r + 5'h01; // [R14]
		end
	end

	// ---------------- control registers and gain curve ----------------
	logic [2:0] ctrl_r;
	afe_stream_pkg::gain_t man_gain_r;
	logic [15:0] step_len_r;
	afe_stream_pkg::gain_t curve_r [0:`CURVE_LEN-1];
	logic soft_rst;
	logic sw_sync;
	logic curve_wr;
	logic [7:0] curve_idx_w;

	assign soft_rst = ctrl_r[`CTRL_SWRST];
	assign curve_wr = spi_wr && ctrl_r[`CTRL_TGCWREN] && wr_addr != `ADDR_CTRL
		&& wr_addr < 8'(`CURVE_LEN + 1);
	assign curve_idx_w = wr_addr - `CURVE_BASE;
	assign sw_sync = spi_wr && !ctrl_r[`CTRL_TGCWREN] && wr_addr == `ADDR_SWSYNC && wr_data[0];

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || soft_rst) begin
			ctrl_r <= `CTRL_RST; // [R13] [R15]
			man_gain_r <= `GAIN_RST;
			step_len_r <= `STEP_RST;
		end else if (spi_wr) begin
			if (wr_addr == `ADDR_CTRL)
				ctrl_r <= wr_data[2:0];
			else if (!ctrl_r[`CTRL_TGCWREN] && wr_addr == `ADDR_GAIN)
				man_gain_r <= wr_data[8:0];
			else if (!ctrl_r[`CTRL_TGCWREN] && wr_addr == `ADDR_STEP)
				step_len_r <= wr_data;
		end
	end

	generate
		for (gi = 0; gi < `CURVE_LEN; gi++) begin : g_curve
			always_ff @(posedge REF_CLK) begin
				if (!RST_N || soft_rst)
					curve_r[gi] <= `GAIN_RST; // [R13]
				else if (curve_wr && curve_idx_w == 8'(gi))
					curve_r[gi] <= wr_data[8:0]; // [R11]
			end
		end
	endgenerate

	function automatic afe_stream_pkg::gain_t clamp_gain(input afe_stream_pkg::gain_t g);
		clamp_gain = (g > `GAIN_MAX) ? `GAIN_MAX : g;
	endfunction

	afe_stream_pkg::curve_state_t cv_r;
	logic [3:0] cv_idx_r;
	logic [15:0] cv_cnt_r;
	logic cv_start;
	logic step_done;

	assign cv_start = sync_pin_evt || sw_sync;
	assign step_done = clk_edge && (cv_cnt_r + 16'h0001 >= step_len_r);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || soft_rst) begin
			cv_r <= afe_stream_pkg::CV_IDLE;
			cv_idx_r <= '0;
			cv_cnt_r <= '0;
		end else if (cv_start) begin
			cv_r <= afe_stream_pkg::CV_RUN; // [R8] [R9]
			cv_idx_r <= '0;
			cv_cnt_r <= '0;
		end else begin
			unique case (cv_r)
				afe_stream_pkg::CV_IDLE: ;
				afe_stream_pkg::CV_RUN: begin
					if (step_done) begin
						cv_cnt_r <= '0;
						if (cv_idx_r == 4'(`CURVE_LEN - 1))
							cv_r <= afe_stream_pkg::CV_HOLD;
						else
							cv_idx_r <= cv_idx_r + 4'h1;
					end else if (clk_edge) begin
						cv_cnt_r <= cv_cnt_r + 16'h0001;
					end
				end
				afe_stream_pkg::CV_HOLD: ;
				default: cv_r <= afe_stream_pkg::CV_IDLE;
			endcase
		end
	end

	// one gain code drives every channel
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			GAIN_CODE <= `GAIN_RST;
			CURVE_RUN <= 1'b0;
		end else begin
			GAIN_CODE <= clamp_gain(cv_r == afe_stream_pkg::CV_IDLE ? man_gain_r
				: curve_r[cv_idx_r]); // [R10] [R11]
			CURVE_RUN <= (cv_r == afe_stream_pkg::CV_RUN);
		end
	end

	// ---------------- checks ----------------
	a_alternate_channel: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R1]
		clk_edge |=> phase_r != $past(phase_r)) else $error("channel did not alternate");
	a_latency_eleven: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R3]
		emerge |-> fill_r == 5'd11 && clk_edge) else $error("word left pipeline early");
	a_offset_binary: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R4]
		clk_edge |=> pipe_r[0][11] == !$past(samp_sel[11])) else $error("coding not offset binary");
	a_frame_word: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R6]
		$rose(FCLK) |-> FCLK[*6] ##1 !FCLK[*6]) else $error("frame clock not word aligned");
	a_msb_first: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R16]
		fifo_pop |=> ##1 DOUT_A == $past(fifo_data[23], 2) && FCLK)
		else $error("first bit is not the top bit");
	a_bit_toggle: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R7]
		DCLK |=> !DCLK ##1 DCLK) else $error("bit clock stopped");
	a_sync_start: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R8]
		(sync_pin_evt && !soft_rst) |=> cv_r == afe_stream_pkg::CV_RUN && cv_idx_r == 4'h0)
		else $error("sync did not start curve");
	a_sw_sync: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R9]
		(sw_sync && !soft_rst) |=> ##1 CURVE_RUN) else $error("software sync ignored");
	a_gain_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
		GAIN_CODE <= `GAIN_MAX) else $error("gain code out of range");
	a_swreset_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R15]
		(spi_wr && wr_addr == `ADDR_CTRL && wr_data[0] && !soft_rst) |=> soft_rst ##1
		(ctrl_r == 3'h0 && cv_r == afe_stream_pkg::CV_IDLE)) else $error("software reset stuck");
	a_group_24: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R14]
		spi_wr |-> spi_cnt_r == 5'd23 && !sen_n_s) else $error("write off a 24-clock group");
endmodule

// [src/afe_stream_pkg.sv]
package afe_stream_pkg;
	typedef logic [8:0] gain_t;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_SHIFT = 2'b01
	} ser_state_t;
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_RUN = 2'b01,
		CV_HOLD = 2'b11
	} curve_state_t;
endpackage

// [src/afe_stream_regs.svh]
`ifndef AFE_STREAM_REGS_SVH
`define AFE_STREAM_REGS_SVH

// converter and serial link
`define WORD_W 12
`define PIPE_LAT 11
`define FRAME_HALF 6
`define PAIR_W 24

// serial programming port
`define SPI_BITS 24
`define SPI_LAST 5'h17

// control register space
`define ADDR_CTRL 8'h00
`define ADDR_GAIN 8'h01
`define ADDR_STEP 8'h02
`define ADDR_SWSYNC 8'h03
`define CURVE_BASE 8'h01
`define CTRL_SWRST 0
`define CTRL_RDEN 1
`define CTRL_TGCWREN 2
`define CTRL_RST 3'h0
`define GAIN_RST 9'h000
`define STEP_RST 16'h0000

// gain code: 0.125 dB per step, 0 is -5 dB, 288 is 31 dB
`define GAIN_MAX 9'h120
`define CURVE_LEN 16

`endif

// [src/word_fifo.sv]
`timescale 1ns/1ns
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW-1:0] rd_ptr_nxt;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// head word is registered; a write into the head slot is forwarded
	always_ff @(posedge clk) begin
		if (push && wr_ptr_r == rd_ptr_nxt)
			out_data <= in_data;
		else
			out_data <= mem_r[rd_ptr_nxt];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule
